// *** design/lsra_regs.sv ***
// Sample interval, result, threshold and alarm control register slice.
`timescale 1ns/100ps
// ==============================================================
module lsra_regs (
	input  wire logic               core_clk,
	input  wire logic               rstn,
	input  wire lsra_pkg::lsra_wr_t wr,
	input  wire logic [9:0]         rd_addr,
	output logic [7:0]              rd_data,
	input  wire logic               mission_active,
	input  wire logic               forced_conv,
	input  wire logic               humid_log_enable,
	input  wire logic               temp_format_select,
	input  wire logic               humid_format_select,
	input  wire logic               fast_sample_select,
	input  wire lsra_pkg::lsra_temp_t temp_in,
	input  wire logic               humid_valid,
	input  wire logic [15:0]        humid_word,
	output logic                    humid_req,
	output logic [13:0]             interval_eff,
	output logic                    interval_seconds,
	output logic                    log_wr,
	output logic [7:0]              log_byte_hi,
	output logic [7:0]              log_byte_lo,
	output logic                    log_two_bytes,
	output lsra_pkg::lsra_flags_t   flags
);

	// ==========================================================
	// Register state
	logic [7:0]  si_low_ff,  nxt_si_low;
	logic [5:0]  si_high_ff, nxt_si_high;
	logic [7:0]  t_lo_thr_ff, nxt_t_lo_thr;
	logic [7:0]  t_hi_thr_ff, nxt_t_hi_thr;
	logic [7:0]  h_lo_thr_ff, nxt_h_lo_thr;
	logic [7:0]  h_hi_thr_ff, nxt_h_hi_thr;
	logic [1:0]  t_en_ff,    nxt_t_en;
	logic [1:0]  h_en_ff,    nxt_h_en;
	logic [15:0] t_res_ff,   nxt_t_res;
	logic [15:0] h_res_ff,   nxt_h_res;
	logic        h_req_ff,   nxt_h_req;
	logic [7:0]  rd_ff,      nxt_rd;
	logic [13:0] ivl_ff,     nxt_ivl;
	logic        ivs_ff,     nxt_ivs;
	logic        lw_ff,      nxt_lw;
	logic [7:0]  lhi_ff,     nxt_lhi;
	logic [7:0]  llo_ff,     nxt_llo;
	logic        l2_ff,      nxt_l2;
	lsra_pkg::lsra_flags_t fl_ff, nxt_fl;

	function automatic logic hit(input logic [9:0] a);
		hit = wr.we && (wr.addr == a);
	endfunction

	// ==========================================================
	// Writable registers
	always_comb begin
		nxt_si_low   = si_low_ff;
		nxt_si_high  = si_high_ff;
		nxt_t_lo_thr = t_lo_thr_ff;
		nxt_t_hi_thr = t_hi_thr_ff;
		nxt_h_lo_thr = h_lo_thr_ff;
		nxt_h_hi_thr = h_hi_thr_ff;
		nxt_t_en     = t_en_ff;
		nxt_h_en     = h_en_ff;
		// Writes during a mission are simply dropped, no error is raised.
		if (!mission_active) begin
			if (hit(lsra_pkg::ADDR_SI_LOW))
				nxt_si_low = wr.wdata;
			if (hit(lsra_pkg::ADDR_SI_HIGH))
				nxt_si_high = wr.wdata[5:0];
			if (hit(lsra_pkg::ADDR_T_LOW_THR))
				nxt_t_lo_thr = wr.wdata;
			if (hit(lsra_pkg::ADDR_T_HIGH_THR))
				nxt_t_hi_thr = wr.wdata;
			if (hit(lsra_pkg::ADDR_H_LOW_THR))
				nxt_h_lo_thr = wr.wdata;
			if (hit(lsra_pkg::ADDR_H_HIGH_THR))
				nxt_h_hi_thr = wr.wdata;
			if (hit(lsra_pkg::ADDR_T_CTRL))
				nxt_t_en = wr.wdata[1:0];
			if (hit(lsra_pkg::ADDR_H_CTRL))
				nxt_h_en = wr.wdata[1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			si_low_ff   <= lsra_pkg::RST_BYTE;
			si_high_ff  <= 6'h00;
			t_lo_thr_ff <= lsra_pkg::RST_BYTE;
			t_hi_thr_ff <= lsra_pkg::RST_BYTE;
			h_lo_thr_ff <= lsra_pkg::RST_BYTE;
			h_hi_thr_ff <= lsra_pkg::RST_BYTE;
			t_en_ff     <= 2'h0;
			h_en_ff     <= 2'h0;
		end else begin
			si_low_ff   <= nxt_si_low;
			si_high_ff  <= nxt_si_high;
			t_lo_thr_ff <= nxt_t_lo_thr;
			t_hi_thr_ff <= nxt_t_hi_thr;
			h_lo_thr_ff <= nxt_h_lo_thr;
			h_hi_thr_ff <= nxt_h_hi_thr;
			t_en_ff     <= nxt_t_en;
			h_en_ff     <= nxt_h_en;
		end
	end

	// ==========================================================
	// Results, logging bytes and alarm flags
	logic [13:0] si_raw;
	logic [15:0] t_code;
	logic        t_fire;
	logic        h_fire;

	// ==========================================================
	// Interval mapping
	always_comb begin
		si_raw = {si_high_ff, si_low_ff};
		nxt_ivl = (si_raw == lsra_pkg::SI_ZERO) ? lsra_pkg::SI_MIN
							: si_raw;
		nxt_ivs = fast_sample_select;
	end

	always_comb begin
		// Temperature word: bits 10..3 high byte, 2..0 on top of low.
		if (temp_in.too_cold)
			t_code = lsra_pkg::T_TOO_COLD;
		else if (temp_in.too_hot)
			t_code = temp_format_select ? lsra_pkg::T_TOO_HOT_16
						: lsra_pkg::T_TOO_HOT_8;
		else
			t_code = {temp_in.value, 5'h00};
		t_fire = temp_in.valid;
		h_fire = humid_valid && h_req_ff;
		nxt_t_res = t_res_ff;
		nxt_h_res = h_res_ff;
		nxt_fl    = fl_ff;
		nxt_lw    = 1'b0;
		nxt_lhi   = lhi_ff;
		nxt_llo   = llo_ff;
		nxt_l2    = l2_ff;
		nxt_h_req = h_req_ff;
		if (forced_conv || (mission_active && humid_log_enable))
			nxt_h_req = 1'b1;
		// A temperature result wins a clash with a humidity reply; the
		// request stays up, so the sensor is simply asked again.
		if (t_fire) begin
			nxt_t_res = t_code & {8'hff, lsra_pkg::T_RES_LOW_MASK};
			nxt_lhi   = t_code[15:8];
			nxt_llo   = t_code[7:0];
			nxt_l2    = temp_format_select;
			nxt_lw    = mission_active;
			if (mission_active) begin
				if (t_en_ff[lsra_pkg::HIGH_EN_BIT]
				    && t_code[15:8] >= t_hi_thr_ff)
					nxt_fl.temp_high_flag = 1'b1;
				if (t_en_ff[lsra_pkg::LOW_EN_BIT]
				    && t_code[15:8] <= t_lo_thr_ff)
					nxt_fl.temp_low_flag = 1'b1;
			end
		end else if (h_fire) begin
			// Whole 16-bit word kept; low nibble passes through unaltered.
			nxt_h_res = humid_word;
			nxt_h_req = 1'b0;
			nxt_lhi   = humid_word[15:8];
			nxt_llo   = humid_word[7:0];
			nxt_l2    = humid_format_select;
			nxt_lw    = mission_active && humid_log_enable;
			if (mission_active) begin
				if (h_en_ff[lsra_pkg::HIGH_EN_BIT]
				    && humid_word[15:8] >= h_hi_thr_ff)
					nxt_fl.humid_high_flag = 1'b1;
				if (h_en_ff[lsra_pkg::LOW_EN_BIT]
				    && humid_word[15:8] <= h_lo_thr_ff)
					nxt_fl.humid_low_flag = 1'b1;
			end
		end
	end

	// ==========================================================
	// Read multiplexer
	always_comb begin
		case (rd_addr)
			lsra_pkg::ADDR_SI_LOW:     nxt_rd = si_low_ff;
			lsra_pkg::ADDR_SI_HIGH:    nxt_rd = {2'b00, si_high_ff};
			lsra_pkg::ADDR_T_LOW_THR:  nxt_rd = t_lo_thr_ff;
			lsra_pkg::ADDR_T_HIGH_THR: nxt_rd = t_hi_thr_ff;
			lsra_pkg::ADDR_H_LOW_THR:  nxt_rd = h_lo_thr_ff;
			lsra_pkg::ADDR_H_HIGH_THR: nxt_rd = h_hi_thr_ff;
			lsra_pkg::ADDR_T_RES_LOW:  nxt_rd = t_res_ff[7:0];
			lsra_pkg::ADDR_T_RES_HIGH: nxt_rd = t_res_ff[15:8];
			lsra_pkg::ADDR_H_RES_LOW:  nxt_rd = h_res_ff[7:0];
			lsra_pkg::ADDR_H_RES_HIGH: nxt_rd = h_res_ff[15:8];
			lsra_pkg::ADDR_T_CTRL:
				nxt_rd = lsra_pkg::T_CTRL_FIXED | {6'h00, t_en_ff};
			lsra_pkg::ADDR_H_CTRL:
				nxt_rd = lsra_pkg::H_CTRL_FIXED | {6'h00, h_en_ff};
			default:                   nxt_rd = 8'h00;
		endcase
	end

	// ==========================================================
	// Result registers and humidity request
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			t_res_ff <= 16'h0000;
			h_res_ff <= 16'h0000;
			h_req_ff <= 1'b0;
		end else begin
			t_res_ff <= nxt_t_res;
			h_res_ff <= nxt_h_res;
			h_req_ff <= nxt_h_req;
		end
	end

	// ==========================================================
	// Interval registers
	// The mapped interval is registered, so the sample timer never sees
	// the raw zero that a host leaves between its two byte writes.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ivl_ff <= lsra_pkg::SI_MIN;
			ivs_ff <= 1'b0;
		end else begin
			ivl_ff <= nxt_ivl;
			ivs_ff <= nxt_ivs;
		end
	end

	// ==========================================================
	// Log strobe and bytes
	// The bytes hold after the strobe, so the log memory may take them
	// a cycle late; that costs sixteen flops but no handshake.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lw_ff  <= 1'b0;
			lhi_ff <= 8'h00;
			llo_ff <= 8'h00;
			l2_ff  <= 1'b0;
		end else begin
			lw_ff  <= nxt_lw;
			lhi_ff <= nxt_lhi;
			llo_ff <= nxt_llo;
			l2_ff  <= nxt_l2;
		end
	end

	// ==========================================================
	// Alarm flags
	// Flags are sticky; clearing belongs to the status register outside
	// this slice, so only reset brings them back to zero.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fl_ff <= '0;
		end else begin
			fl_ff <= nxt_fl;
		end
	end

	// ==========================================================
	// Read data register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_ff <= 8'h00;
		end else begin
			rd_ff <= nxt_rd;
		end
	end

	assign rd_data          = rd_ff;
	assign humid_req        = h_req_ff;
	assign interval_eff     = ivl_ff;
	assign interval_seconds = ivs_ff;
	assign log_wr           = lw_ff;
	assign log_byte_hi      = lhi_ff;
	assign log_byte_lo      = llo_ff;
	assign log_two_bytes    = l2_ff;
	assign flags            = fl_ff;

endmodule

// *** design/lsra_pkg.sv ***
// Package for the logger sensor result and alarm register slice.
package lsra_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [9:0] ADDR_SI_LOW     = 10'h206;
	localparam logic [9:0] ADDR_SI_HIGH    = 10'h207;
	localparam logic [9:0] ADDR_T_LOW_THR  = 10'h208;
	localparam logic [9:0] ADDR_T_HIGH_THR = 10'h209;
	localparam logic [9:0] ADDR_H_LOW_THR  = 10'h20a;
	localparam logic [9:0] ADDR_H_HIGH_THR = 10'h20b;
	localparam logic [9:0] ADDR_T_RES_LOW  = 10'h20c;
	localparam logic [9:0] ADDR_T_RES_HIGH = 10'h20d;
	localparam logic [9:0] ADDR_H_RES_LOW  = 10'h20e;
	localparam logic [9:0] ADDR_H_RES_HIGH = 10'h20f;
	localparam logic [9:0] ADDR_T_CTRL     = 10'h210;
	localparam logic [9:0] ADDR_H_CTRL     = 10'h211;

	// ==========================================================
	// Field layouts and reset values
	localparam int         SI_HIGH_BITS    = 6;
	localparam int         HIGH_EN_BIT     = 1;
	localparam int         LOW_EN_BIT      = 0;
	localparam logic [7:0] T_CTRL_FIXED    = 8'h00;
	localparam logic [7:0] H_CTRL_FIXED    = 8'hfc;
	localparam logic [7:0] T_RES_LOW_MASK  = 8'he0;
	localparam logic [7:0] RST_BYTE        = 8'h00;
	localparam logic [13:0] SI_ZERO        = 14'h0000;
	localparam logic [13:0] SI_MIN         = 14'h0001;
	localparam logic [15:0] T_TOO_HOT_16   = 16'hffe0;
	localparam logic [15:0] T_TOO_HOT_8    = 16'hff00;
	localparam logic [15:0] T_TOO_COLD     = 16'h0000;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        we;
		logic [9:0]  addr;
		logic [7:0]  wdata;
	} lsra_wr_t;

	typedef struct packed {
		logic        valid;
		logic        too_cold;
		logic        too_hot;
		logic [10:0] value;
	} lsra_temp_t;

	typedef struct packed {
		logic        temp_high_flag;
		logic        temp_low_flag;
		logic        humid_high_flag;
		logic        humid_low_flag;
	} lsra_flags_t;

endpackage

// *** tb/lsra_humid_sensor.sv ***
// Behavioural humidity sensor that answers fetch requests after a lag.
`timescale 1ns/100ps
module lsra_humid_sensor (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        humid_req,
	input  wire logic [3:0]  lag,
	input  wire logic [15:0] sample,
	output logic             humid_valid,
	output logic [15:0]      humid_word
);
	logic [3:0] wait_ff;
	logic       fire;
	assign fire = humid_req && !humid_valid && wait_ff >= lag;
	// Outside a reply the word flips every cycle so a stale sample never
	// looks like a fresh one.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wait_ff <= 4'h0;
			humid_valid <= 1'b0;
			humid_word <= 16'h0000;
		end else begin
			wait_ff <= (humid_req && !fire) ? wait_ff + 4'h1 : 4'h0;
			humid_valid <= fire;
			humid_word <= fire ? sample : ~humid_word;
		end
	end
endmodule

// *** tb/lsra_regs_sva.sv ***
// Assertion checker for the sensor result and alarm register slice.
`timescale 1ns/100ps
module lsra_regs_sva (
	input wire logic                  core_clk,
	input wire logic                  rstn,
	input wire logic [9:0]            rd_addr,
	input wire logic [7:0]            rd_data,
	input wire logic                  mission_active,
	input wire logic [13:0]           interval_eff,
	input wire logic                  log_wr,
	input wire lsra_pkg::lsra_flags_t flags
);
	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_si_hold; (mission_active && rd_addr == lsra_pkg::ADDR_SI_LOW)
		[*2] |=> $stable(rd_data); endproperty
	a_si_hold: assert property (p_si_hold) else $error("interval moved");
	property p_si_top; rd_addr == lsra_pkg::ADDR_SI_HIGH
		|=> rd_data[7:6] == 2'h0; endproperty
	a_si_top: assert property (p_si_top) else $error("interval top set");
	property p_tlo; rd_addr == lsra_pkg::ADDR_T_RES_LOW
		|=> rd_data[4:0] == 5'h00; endproperty
	a_tlo: assert property (p_tlo) else $error("temp low bits set");
	property p_tc; rd_addr == lsra_pkg::ADDR_T_CTRL
		|=> rd_data[7:2] == 6'h00; endproperty
	a_tc: assert property (p_tc) else $error("temp control fill");
	property p_hc; rd_addr == lsra_pkg::ADDR_H_CTRL
		|=> rd_data[7:2] == 6'h3f; endproperty
	a_hc: assert property (p_hc) else $error("humid control fill");
	property p_tc_hold; (mission_active && rd_addr == lsra_pkg::ADDR_T_CTRL)
		[*2] |=> $stable(rd_data); endproperty
	a_tc_hold: assert property (p_tc_hold) else $error("control moved");
	property p_ieff; interval_eff != 14'h0000; endproperty
	a_ieff: assert property (p_ieff) else $error("zero interval");
	property p_log; log_wr |-> $past(mission_active); endproperty
	a_log: assert property (p_log) else $error("log outside mission");
	property p_flag; flags != $past(flags) |-> $past(mission_active);
	endproperty
	a_flag: assert property (p_flag) else $error("flag off mission");
endmodule

// *** tb/logger_sensor_result_alarm_regs_bench.sv ***
// Self-checking bench for the sensor result and alarm register slice.
`timescale 1ns/100ps
module logger_sensor_result_alarm_regs_bench;
	typedef struct packed {
		logic [9:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} lsra_row_t;
	logic                  core_clk = 1'b0;
	logic                  rstn = 1'b0;
	lsra_pkg::lsra_wr_t    wr = 19'h00000;
	logic [9:0]            rd_addr = 10'h000;
	logic                  mission_active = 1'b0;
	logic                  forced_conv = 1'b0;
	logic                  humid_log_enable = 1'b0;
	logic                  temp_format_select = 1'b1;
	logic                  humid_format_select = 1'b0;
	logic                  fast_sample_select = 1'b1;
	lsra_pkg::lsra_temp_t  temp_in = 14'h0000;
	logic [15:0]           sample = 16'h0000;
	logic [3:0]            lag = 4'h0;
	logic [7:0]            rd_data, log_byte_hi, log_byte_lo;
	logic                  humid_valid, humid_req, interval_seconds;
	logic                  log_wr, log_two_bytes;
	logic [15:0]           humid_word;
	logic [13:0]           interval_eff;
	lsra_pkg::lsra_flags_t flags;
	int                    bad_count = 0;
	int                    n_tests = 0;
	lsra_row_t rows [12] = '{
		'{10'h206, 8'ha5, 8'ha5}, '{10'h206, 8'h00, 8'h00},
		'{10'h207, 8'hff, 8'h3f},
		'{10'h208, 8'h3e, 8'h3e}, '{10'h209, 8'h85, 8'h85},
		'{10'h20a, 8'h58, 8'h58}, '{10'h20b, 8'h97, 8'h97},
		'{10'h210, 8'hff, 8'h03},
		'{10'h211, 8'h00, 8'hfc}, '{10'h211, 8'h03, 8'hff},
		'{10'h20d, 8'h55, 8'h00}, '{10'h3ff, 8'h77, 8'h00}};
	always #4 core_clk = ~core_clk;
	lsra_regs i_lsra_regs (
		.core_clk            (core_clk),
		.rstn                (rstn),
		.wr                  (wr),
		.rd_addr             (rd_addr),
		.rd_data             (rd_data),
		.mission_active      (mission_active),
		.forced_conv         (forced_conv),
		.humid_log_enable    (humid_log_enable),
		.temp_format_select  (temp_format_select),
		.humid_format_select (humid_format_select),
		.fast_sample_select  (fast_sample_select),
		.temp_in             (temp_in),
		.humid_valid         (humid_valid),
		.humid_word          (humid_word),
		.humid_req           (humid_req),
		.interval_eff        (interval_eff),
		.interval_seconds    (interval_seconds),
		.log_wr              (log_wr),
		.log_byte_hi         (log_byte_hi),
		.log_byte_lo         (log_byte_lo),
		.log_two_bytes       (log_two_bytes),
		.flags               (flags)
	);
	lsra_humid_sensor i_lsra_humid_sensor (
		.core_clk    (core_clk),
		.rstn        (rstn),
		.humid_req   (humid_req),
		.lag         (lag),
		.sample      (sample),
		.humid_valid (humid_valid),
		.humid_word  (humid_word)
	);
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(logic [9:0] a, logic [7:0] d);
		@(posedge core_clk);
		wr <= {1'b1, a, d};
		@(posedge core_clk);
		wr <= {1'b0, a, d};
	endtask
	task automatic rd_chk(logic [9:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
		rd_addr <= a;
		repeat (2) @(posedge core_clk);
		#1 check($sformatf("reg %h", a), {8'h00, rd_data & m}, {8'h00, e});
	endtask
	task automatic temp(logic cold, logic hot, logic [10:0] v);
		@(posedge core_clk);
		temp_in <= {1'b1, cold, hot, v};
		@(posedge core_clk);
		temp_in.valid <= 1'b0;
		#1;
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// Sequence
	initial begin
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		#1 check("interval", {2'h0, interval_eff}, 16'h0001);
		rd_chk(lsra_pkg::ADDR_H_CTRL, 8'hfc);
		$display("test reset done");
		foreach (rows[i]) begin
			wr_reg(rows[i].a, rows[i].d);
			rd_chk(rows[i].a, rows[i].e);
		end
		wr_reg(lsra_pkg::ADDR_SI_HIGH, 8'h00);
		fast_sample_select <= 1'b0;
		rd_chk(lsra_pkg::ADDR_SI_HIGH, 8'h00);
		check("interval", {1'b0, interval_seconds, interval_eff}, 16'h0001);
		$display("test registers done");
		// A high reading between missions must not raise any flag.
		sample <= 16'hb5c3;
		forced_conv <= 1'b1;
		@(posedge core_clk);
		forced_conv <= 1'b0;
		#1 check("humid req", {15'h0000, humid_req}, 16'h0001);
		repeat (4) @(posedge core_clk);
		rd_chk(lsra_pkg::ADDR_H_RES_HIGH, 8'hb5);
		rd_chk(lsra_pkg::ADDR_H_RES_LOW, 8'hc0, 8'hf0);
		check("flags", {12'h000, flags}, 16'h0000);
		$display("test forced done");
		mission_active <= 1'b1;
		// Reads point at the target first, so the hold checks see the try.
		rd_addr <= lsra_pkg::ADDR_SI_LOW;
		wr_reg(lsra_pkg::ADDR_SI_LOW, 8'h12);
		rd_chk(lsra_pkg::ADDR_SI_LOW, 8'h00);
		rd_addr <= lsra_pkg::ADDR_T_CTRL;
		wr_reg(lsra_pkg::ADDR_T_CTRL, 8'h00);
		rd_chk(lsra_pkg::ADDR_T_CTRL, 8'h03);
		temp(1'b0, 1'b0, 11'h1f7);
		check("log", {6'h00, log_wr, log_two_bytes, log_byte_hi}, 16'h033e);
		check("log low", {8'h00, log_byte_lo}, 16'h00e0);
		check("flags", {12'h000, flags}, 16'h0004);
		temp(1'b0, 1'b1, 11'h000);
		rd_chk(lsra_pkg::ADDR_T_RES_HIGH, 8'hff);
		rd_chk(lsra_pkg::ADDR_T_RES_LOW, 8'he0);
		temp_format_select <= 1'b0;
		temp(1'b1, 1'b0, 11'h7ff);
		check("log", {6'h00, log_wr, log_two_bytes, log_byte_hi}, 16'h0200);
		check("flags", {12'h000, flags}, 16'h000c);
		$display("test temperature done");
		// The slow sensor reply leaves time for the format change to settle.
		sample <= 16'h3074;
		lag <= 4'h5;
		humid_log_enable <= 1'b1;
		for (int f = 0; f < 2; f++) begin
			humid_format_select <= f[0];
			@(posedge core_clk) #1;
			for (int i = 0; i < 40 && log_wr !== 1'b1; i++)
				@(posedge core_clk) #1;
			check("humid log", {6'h00, log_wr, log_two_bytes, log_byte_hi},
				{6'h00, 1'b1, f[0], 8'h30});
		end
		check("flags", {12'h000, flags}, 16'h000d);
		// A reading equal to the high threshold must raise the high flag.
		sample <= 16'h9700;
		@(posedge core_clk) #1;
		for (int i = 0; i < 40 && log_wr !== 1'b1; i++)
			@(posedge core_clk) #1;
		humid_log_enable <= 1'b0;
		check("flags", {12'h000, flags}, 16'h000f);
		mission_active <= 1'b0;
		$display("test humidity done");
		stop_test();
	end
	initial begin
		#40000;
		bad_count++;
		stop_test();
	end
endmodule
bind lsra_regs lsra_regs_sva i_lsra_regs_sva (
	.core_clk       (core_clk),
	.rstn           (rstn),
	.rd_addr        (rd_addr),
	.rd_data        (rd_data),
	.mission_active (mission_active),
	.interval_eff   (interval_eff),
	.log_wr         (log_wr),
	.flags          (flags)
);
